// *** srcd_cfg.svh ***
// secure region host constants
`ifndef SRCD_CFG_SVH
`define SRCD_CFG_SVH

// bus widths
`define SRCD_AW           23
`define SRCD_DW           16

// unlock and command words
`define SRCD_UNLOCK1_ADDR 23'h000555
`define SRCD_UNLOCK1_DATA 16'h00aa
`define SRCD_UNLOCK2_ADDR 23'h0002aa
`define SRCD_UNLOCK2_DATA 16'h0055
`define SRCD_CMD_ADDR     23'h000555
`define SRCD_ENTER_DATA   16'h0088
`define SRCD_PSETUP_DATA  16'h00a0
`define SRCD_EXIT_DATA    16'h0090
`define SRCD_EXIT2_DATA   16'h0000

// region and sector address widths
`define SRCD_REGION_AW    7
`define SRCD_SECTOR_AW    16

// toggle status bit
`define SRCD_TOGGLE_BIT   6

// clock and bus timing
`define SRCD_CLK_MHZ      25
`define SRCD_TAS_NS       10
`define SRCD_TWP_NS       35
`define SRCD_TWPH_NS      30
`define SRCD_TACC_NS      100
`define SRCD_TRP_NS       500
`define SRCD_NS2CYC(ns)   (((ns) * `SRCD_CLK_MHZ + 999) / 1000)
`define SRCD_TAS_CYC      `SRCD_NS2CYC(`SRCD_TAS_NS)
`define SRCD_TWP_CYC      `SRCD_NS2CYC(`SRCD_TWP_NS)
`define SRCD_TWPH_CYC     `SRCD_NS2CYC(`SRCD_TWPH_NS)
`define SRCD_TACC_CYC     `SRCD_NS2CYC(`SRCD_TACC_NS)
`define SRCD_TRP_CYC      `SRCD_NS2CYC(`SRCD_TRP_NS)

`endif

// *** srcd_pkg.sv ***
// secure region host types
`default_nettype none
package srcd_pkg;

    // user commands
    typedef enum logic [1:0] {
        SRCD_OP_READ  = 2'h0,
        SRCD_OP_ENTER = 2'h1,
        SRCD_OP_PROG  = 2'h2,
        SRCD_OP_EXIT  = 2'h3
    } srcd_op_t;

    // sequencer states
    typedef enum logic [5:0] {
        SRCD_ST_IDLE  = 6'h01,
        SRCD_ST_ISSUE = 6'h02,
        SRCD_ST_WAIT  = 6'h04,
        SRCD_ST_POLL  = 6'h08,
        SRCD_ST_PWAIT = 6'h10,
        SRCD_ST_DONE  = 6'h20
    } srcd_st_t;

    // bus cycle engine states
    typedef enum logic [4:0] {
        SRCD_E_IDLE  = 5'h01,
        SRCD_E_SETUP = 5'h02,
        SRCD_E_PULSE = 5'h04,
        SRCD_E_HOLD  = 5'h08,
        SRCD_E_READ  = 5'h10
    } srcd_est_t;

endpackage
`default_nettype wire

// *** srcd_cyc_if.sv ***
// sequencer to cycle engine request
`include "srcd_cfg.svh"
`default_nettype none
interface srcd_cyc_if;
    logic                 start;
    logic                 write;
    logic [`SRCD_AW-1:0]  addr;
    logic [`SRCD_DW-1:0]  wdata;
    logic                 done;
    logic [`SRCD_DW-1:0]  rdata;

    modport seq (output start, output write, output addr, output wdata,
                 input done, input rdata);
    modport eng (input start, input write, input addr, input wdata,
                 output done, output rdata);
endinterface
`default_nettype wire

// *** srcd_cycle.sv ***
// one asynchronous flash bus cycle
`include "srcd_cfg.svh"
`default_nettype none
module srcd_cycle
    import srcd_pkg::*;
(
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    srcd_cyc_if.eng                  cyc,
    output logic [`SRCD_AW-1:0]      flash_addr_o,
    input  wire logic [`SRCD_DW-1:0] flash_dq_i,
    output logic [`SRCD_DW-1:0]      flash_dq_o,
    output logic                     flash_dq_oe_o,
    output logic                     flash_ce_n_o,
    output logic                     flash_oe_n_o,
    output logic                     flash_we_n_o
);

    srcd_est_t           est_r;
    logic [7:0]          cnt_r;
    logic [`SRCD_DW-1:0] s1_r;
    logic [`SRCD_DW-1:0] s2_r;
    logic [`SRCD_DW-1:0] s3_r;

    ////////////////////////////////////////////////////////////////////
    // three-stage synchroniser on the data pins
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= 16'h0000;
            s2_r <= 16'h0000;
            s3_r <= 16'h0000;
        end else begin
            s1_r <= flash_dq_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cycle state, strobes and pin drive
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            est_r         <= SRCD_E_IDLE;
            cnt_r         <= 8'h00;
            flash_addr_o  <= '0;
            flash_dq_o    <= 16'h0000;
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o  <= 1'b1;
            flash_oe_n_o  <= 1'b1;
            flash_we_n_o  <= 1'b1;
            cyc.done      <= 1'b0;
            cyc.rdata     <= 16'h0000;
        end else begin
            cyc.done <= 1'b0;
            unique case (est_r)
                SRCD_E_IDLE: begin
                    if (cyc.start) begin
                        flash_addr_o <= cyc.addr;
                        flash_ce_n_o <= 1'b0;
                        if (cyc.write) begin
                            flash_dq_o    <= cyc.wdata;
                            flash_dq_oe_o <= 1'b1;
                            cnt_r         <= 8'(`SRCD_TAS_CYC);
                            est_r         <= SRCD_E_SETUP;
                        end else begin
                            flash_oe_n_o <= 1'b0;
                            cnt_r        <= 8'(`SRCD_TACC_CYC);
                            est_r        <= SRCD_E_READ;
                        end
                    end
                end
                SRCD_E_SETUP: begin
                    if (cnt_r == 8'h01) begin
                        flash_we_n_o <= 1'b0;
                        cnt_r        <= 8'(`SRCD_TWP_CYC);
                        est_r        <= SRCD_E_PULSE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                SRCD_E_PULSE: begin
                    // device latches on rising strobe
                    if (cnt_r == 8'h01) begin
                        flash_we_n_o <= 1'b1;
                        cnt_r        <= 8'(`SRCD_TWPH_CYC);
                        est_r        <= SRCD_E_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                SRCD_E_HOLD: begin
                    if (cnt_r == 8'h01) begin
                        flash_ce_n_o  <= 1'b1;
                        flash_dq_oe_o <= 1'b0;
                        cyc.done      <= 1'b1;
                        est_r         <= SRCD_E_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                SRCD_E_READ: begin
                    // access time, then sync settle
                    if (cnt_r != 8'h01) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else if (s2_r == s3_r) begin
                        cyc.rdata    <= s3_r;
                        cyc.done     <= 1'b1;
                        flash_ce_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        est_r        <= SRCD_E_IDLE;
                    end
                end
                default: begin
                    est_r <= SRCD_E_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// *** srcd_host.sv ***
// secure region enter, program, exit and read sequencer
`include "srcd_cfg.svh"
`default_nettype none
module srcd_host
    import srcd_pkg::*;
#(
    parameter int POLL_MAX = 20000
) (
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    input  wire logic                cmd_valid_i,
    input  wire srcd_op_t            cmd_op_i,
    input  wire logic [`SRCD_AW-1:0] cmd_addr_i,
    input  wire logic [`SRCD_DW-1:0] cmd_data_i,
    output logic                     cmd_ready_o,
    output logic                     done_o,
    output logic                     err_o,
    output logic [`SRCD_DW-1:0]      rdata_o,
    output logic                     rinv_o,
    output logic                     in_region_o,
    output logic [`SRCD_AW-1:0]      flash_addr_o,
    input  wire logic [`SRCD_DW-1:0] flash_dq_i,
    output logic [`SRCD_DW-1:0]      flash_dq_o,
    output logic                     flash_dq_oe_o,
    output logic                     flash_ce_n_o,
    output logic                     flash_oe_n_o,
    output logic                     flash_we_n_o,
    output logic                     flash_reset_n_o
);

    srcd_cyc_if cyc ();

    srcd_st_t            st_r;
    srcd_op_t            op_r;
    logic [`SRCD_AW-1:0] addr_r;
    logic [`SRCD_DW-1:0] data_r;
    logic [1:0]          step_r;
    logic                prev_r;
    logic                have_prev_r;
    logic [31:0]         poll_cnt_r;
    logic [4:0]          rst_cnt_r;
    logic                tog_bit;

    ////////////////////////////////////////////////////////////////////
    // step decoding
    function automatic logic [1:0] last_step(input srcd_op_t op);
        unique case (op)
            SRCD_OP_READ:  last_step = 2'h0;
            SRCD_OP_ENTER: last_step = 2'h2;
            SRCD_OP_PROG:  last_step = 2'h3;
            SRCD_OP_EXIT:  last_step = 2'h3;
        endcase
    endfunction

    function automatic logic [`SRCD_AW-1:0] step_addr(input logic [1:0] step,
                                                     input logic [`SRCD_AW-1:0] ua);
        unique case (step)
            2'h0:    step_addr = `SRCD_UNLOCK1_ADDR;
            2'h1:    step_addr = `SRCD_UNLOCK2_ADDR;
            2'h2:    step_addr = `SRCD_CMD_ADDR;
            2'h3:    step_addr = ua;
        endcase
    endfunction

    function automatic logic [`SRCD_DW-1:0] step_data(input srcd_op_t op,
                                                     input logic [1:0] step,
                                                     input logic [`SRCD_DW-1:0] ud);
        unique case (step)
            2'h0: step_data = `SRCD_UNLOCK1_DATA;
            2'h1: step_data = `SRCD_UNLOCK2_DATA;
            2'h2: begin
                if (op == SRCD_OP_ENTER) begin
                    step_data = `SRCD_ENTER_DATA;
                end else if (op == SRCD_OP_PROG) begin
                    step_data = `SRCD_PSETUP_DATA;
                end else begin
                    step_data = `SRCD_EXIT_DATA;
                end
            end
            2'h3: begin
                if (op == SRCD_OP_PROG) begin
                    step_data = ud;
                end else begin
                    step_data = `SRCD_EXIT2_DATA;
                end
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // request to the cycle engine
    assign cyc.start = (st_r == SRCD_ST_ISSUE) || (st_r == SRCD_ST_POLL);
    assign cyc.write = (st_r == SRCD_ST_ISSUE) && (op_r != SRCD_OP_READ);
    assign cyc.addr  = (st_r == SRCD_ST_ISSUE && op_r != SRCD_OP_READ) ?
                       step_addr(step_r, addr_r) : addr_r;
    assign cyc.wdata = step_data(op_r, step_r, data_r);

    assign tog_bit = cyc.rdata[`SRCD_TOGGLE_BIT];

    // idle and out of reset pulse
    assign cmd_ready_o = (st_r == SRCD_ST_IDLE) && flash_reset_n_o;
    assign done_o      = (st_r == SRCD_ST_DONE);

    ////////////////////////////////////////////////////////////////////
    // device reset pin, low through the pulse
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_cnt_r       <= 5'h00;
            flash_reset_n_o <= 1'b0;
        end else if (rst_cnt_r != 5'(`SRCD_TRP_CYC)) begin
            rst_cnt_r       <= rst_cnt_r + 5'h01;
        end else begin
            flash_reset_n_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer state and step index
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r   <= SRCD_ST_IDLE;
            step_r <= 2'h0;
        end else begin
            unique case (st_r)
                SRCD_ST_IDLE: begin
                    if (cmd_valid_i && cmd_ready_o) begin
                        step_r <= 2'h0;
                        st_r   <= SRCD_ST_ISSUE;
                    end
                end
                SRCD_ST_ISSUE: begin
                    st_r <= SRCD_ST_WAIT;
                end
                SRCD_ST_WAIT: begin
                    // whole sequences only, never a partial one
                    if (cyc.done) begin
                        if (step_r == last_step(op_r)) begin
                            st_r <= (op_r == SRCD_OP_PROG) ? SRCD_ST_POLL
                                                           : SRCD_ST_DONE;
                        end else begin
                            step_r <= step_r + 2'h1;
                            st_r   <= SRCD_ST_ISSUE;
                        end
                    end
                end
                SRCD_ST_POLL: begin
                    st_r <= SRCD_ST_PWAIT;
                end
                SRCD_ST_PWAIT: begin
                    // done when toggle bit holds
                    if (cyc.done) begin
                        if ((have_prev_r && tog_bit == prev_r) ||
                            poll_cnt_r == 32'(POLL_MAX - 1)) begin
                            st_r <= SRCD_ST_DONE;
                        end else begin
                            st_r <= SRCD_ST_POLL;
                        end
                    end
                end
                SRCD_ST_DONE: begin
                    st_r <= SRCD_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command capture
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_r   <= SRCD_OP_READ;
            addr_r <= '0;
            data_r <= 16'h0000;
        end else if (st_r == SRCD_ST_IDLE && cmd_valid_i && cmd_ready_o) begin
            op_r   <= cmd_op_i;
            addr_r <= cmd_addr_i;
            data_r <= cmd_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // completion polling and timeout flag
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r      <= 1'b0;
            have_prev_r <= 1'b0;
            poll_cnt_r  <= 32'h0000_0000;
            err_o       <= 1'b0;
        end else if (st_r == SRCD_ST_IDLE && cmd_valid_i && cmd_ready_o) begin
            have_prev_r <= 1'b0;
            poll_cnt_r  <= 32'h0000_0000;
            err_o       <= 1'b0;
        end else if (st_r == SRCD_ST_PWAIT && cyc.done) begin
            prev_r      <= tog_bit;
            have_prev_r <= 1'b1;
            poll_cnt_r  <= poll_cnt_r + 32'h0000_0001;
            if (!(have_prev_r && tog_bit == prev_r) &&
                poll_cnt_r == 32'(POLL_MAX - 1)) begin
                err_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data and validity of region reads
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
            rinv_o  <= 1'b0;
        end else if (st_r == SRCD_ST_WAIT && cyc.done && op_r == SRCD_OP_READ) begin
            rdata_o <= cyc.rdata;
            rinv_o  <= in_region_o &&
                       (addr_r[`SRCD_AW-1:`SRCD_SECTOR_AW] == '0) &&
                       (addr_r[`SRCD_SECTOR_AW-1:`SRCD_REGION_AW] != '0);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // region mode tracking
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            in_region_o <= 1'b0;
        end else if (st_r == SRCD_ST_DONE && op_r == SRCD_OP_ENTER) begin
            in_region_o <= 1'b1;
        end else if (st_r == SRCD_ST_DONE && op_r == SRCD_OP_EXIT) begin
            in_region_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus cycle engine
    srcd_cycle u_cycle (
        .mclk_i        (mclk_i),
        .rst_i         (rst_i),
        .cyc           (cyc.eng),
        .flash_addr_o  (flash_addr_o),
        .flash_dq_i    (flash_dq_i),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_o (flash_dq_oe_o),
        .flash_ce_n_o  (flash_ce_n_o),
        .flash_oe_n_o  (flash_oe_n_o),
        .flash_we_n_o  (flash_we_n_o)
    );

endmodule
`default_nettype wire

// *** srcd_host_assertions.sv ***
// port checks for the secure region host
`include "srcd_cfg.svh"
`default_nettype none
module srcd_host_assertions (
    input wire logic                mclk_i,
    input wire logic                rst_i,
    input wire logic                cmd_valid_i,
    input wire logic                cmd_ready_o,
    input wire logic                done_o,
    input wire logic                err_o,
    input wire logic                in_region_o,
    input wire logic [`SRCD_AW-1:0] flash_addr_o,
    input wire logic [`SRCD_DW-1:0] flash_dq_o,
    input wire logic                flash_dq_oe_o,
    input wire logic                flash_ce_n_o,
    input wire logic                flash_oe_n_o,
    input wire logic                flash_we_n_o,
    input wire logic                flash_reset_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] rlow_r;
    ////////////////////////////////////////////////////////////////
    // cycles reset pin held low
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            rlow_r <= 8'h00;
        else if (!flash_reset_n_o && rlow_r != 8'hff)
            rlow_r <= rlow_r + 8'h01;
    end
    ////////////////////////////////////////////////////////////////
    reset_pins_a: assert property (disable iff (1'b0) rst_i |->
        flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o && !flash_reset_n_o)
        else $error("pins not parked");
    reset_len_a: assert property ($rose(flash_reset_n_o) |-> rlow_r >= 8'd13)
        else $error("reset pulse short");
    ready_gate_a: assert property (!flash_reset_n_o |-> !cmd_ready_o)
        else $error("ready in reset");
    take_busy_a: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o [*2])
        else $error("taken while busy");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done too long");
    we_frame_a: assert property (!flash_we_n_o |->
        !flash_ce_n_o && flash_dq_oe_o && flash_oe_n_o)
        else $error("strobe unframed");
    we_width_a: assert property ($fell(flash_we_n_o) |=> flash_we_n_o && !flash_ce_n_o)
        else $error("strobe width");
    write_hold_a: assert property (!flash_we_n_o |=>
        $stable(flash_addr_o) && $stable(flash_dq_o) && flash_dq_oe_o)
        else $error("write not held");
    read_float_a: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
        else $error("drive in read");
    ce_gap_a: assert property ($rose(flash_ce_n_o) |=> flash_ce_n_o)
        else $error("select gap short");
    region_cause_a: assert property ($changed(in_region_o) |-> $past(done_o))
        else $error("region without done");
    // main scenarios reached
    cover property ($rose(in_region_o));
    cover property ($fell(in_region_o));
    cover property ($rose(err_o));
    cover property (done_o && in_region_o);
endmodule
bind srcd_host srcd_host_assertions u_chk (.*);
`default_nettype wire

// *** srcd_flash_model.sv ***
// flash device model for the region sequences
`include "srcd_cfg.svh"
`default_nettype none
module srcd_flash_model (
    input  wire logic [`SRCD_AW-1:0] addr_i,
    input  wire logic [`SRCD_DW-1:0] dq_i,
    output logic      [`SRCD_DW-1:0] dq_o,
    input  wire logic                ce_n_i,
    input  wire logic                oe_n_i,
    input  wire logic                we_n_i,
    input  wire logic                reset_n_i,
    input  wire logic [7:0]          busy_rd_i,
    output logic                     region_o,
    output logic                     bad_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [`SRCD_DW-1:0] reg_mem [128];
    logic [`SRCD_DW-1:0] rd;
    logic [`SRCD_DW-1:0] last_q;
    logic [2:0]          step_r;
    logic [2:0]          nx;
    logic [7:0]          busy_r;
    logic                stat_r;
    logic                tog_r;
    logic                drv;
    logic                in_sec;
    logic                in_reg;
    logic                cm;
    logic                u1;
    logic                u2;
    assign drv = !ce_n_i && !oe_n_i && reset_n_i;
    assign in_sec = addr_i[`SRCD_AW-1:`SRCD_SECTOR_AW] == '0;
    assign in_reg = in_sec && addr_i[`SRCD_SECTOR_AW-1:`SRCD_REGION_AW] == '0;
    assign cm = addr_i == `SRCD_CMD_ADDR;
    assign u1 = addr_i == `SRCD_UNLOCK1_ADDR && dq_i == `SRCD_UNLOCK1_DATA;
    assign u2 = addr_i == `SRCD_UNLOCK2_ADDR && dq_i == `SRCD_UNLOCK2_DATA;
    initial begin
        bad_o = 1'b0;
        tog_r = 1'b0;
        last_q = 16'h0000;
        for (int i = 0; i < 128; i++)
            reg_mem[i] = 16'hc000 | 16'(i);
    end
    ////////////////////////////////////////////////////////////////
    // status, region or array word
    always @* begin
        if (stat_r)
            rd = {9'h000, tog_r, 6'h00};
        else if (region_o && in_sec)
            rd = in_reg ? reg_mem[addr_i[6:0]] : 16'hdead;
        else
            rd = addr_i[15:0] ^ 16'h3c3c;
        if (drv)
            last_q = rd;
    end
    // released lines show the inverse of the last word
    assign dq_o = drv ? rd : ~last_q;
    ////////////////////////////////////////////////////////////////
    // decoder on rising strobe
    always @(posedge we_n_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            region_o = 1'b0;
            step_r = 3'd0;
            busy_r = 8'h00;
            stat_r = 1'b0;
        end else if (!ce_n_i) begin
            if (busy_r != 8'h00)
                bad_o = 1'b1;
            nx = 3'd0;
            case (step_r)
                3'd0: nx = u1 ? 3'd1 : 3'd5;
                3'd1: nx = u2 ? 3'd2 : 3'd5;
                3'd2: nx = !cm ? 3'd5 : dq_i == `SRCD_PSETUP_DATA ? 3'd3
                         : dq_i == `SRCD_EXIT_DATA ? 3'd4 : 3'd6;
                3'd3: begin
                    if (region_o && in_reg)
                        reg_mem[addr_i[6:0]] = dq_i;
                    busy_r = busy_rd_i;
                end
                default: nx = dq_i == `SRCD_EXIT2_DATA ? 3'd7 : 3'd5;
            endcase
            if (nx == 3'd6 && dq_i == `SRCD_ENTER_DATA)
                region_o = 1'b1;
            else if (nx == 3'd7)
                region_o = 1'b0;
            else if (nx == 3'd5)
                bad_o = 1'b1;
            step_r = (nx > 3'd4) ? 3'd0 : nx;
        end
    end
    // busy reads flip toggle bit
    always @(negedge oe_n_i) begin
        stat_r = busy_r != 8'h00;
        if (stat_r) begin
            busy_r = busy_r - 8'h01;
            tog_r = ~tog_r;
        end
    end
endmodule
`default_nettype wire

// *** srcd_host_tb.sv ***
// self-checking bench for the secure region command host
`include "srcd_cfg.svh"
`default_nettype none
module srcd_host_tb import srcd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic                mclk_i;
    logic                rst_i;
    logic                cmd_valid_i;
    srcd_op_t            cmd_op_i;
    logic [`SRCD_AW-1:0] cmd_addr_i;
    logic [`SRCD_DW-1:0] cmd_data_i;
    logic                cmd_ready_o;
    logic                done_o;
    logic                err_o;
    logic [`SRCD_DW-1:0] rdata_o;
    logic                rinv_o;
    logic                in_region_o;
    logic [`SRCD_AW-1:0] flash_addr_o;
    logic [`SRCD_DW-1:0] flash_dq_o;
    logic [`SRCD_DW-1:0] mdl_dq;
    wire logic [15:0]    dq_bus;
    logic                flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
    logic                flash_reset_n_o;
    logic [7:0]          busy_rd;
    logic                region;
    logic                bad;
    int                  miscompares;
    int                  cmp_count;
    assign dq_bus = flash_dq_oe_o ? flash_dq_o : mdl_dq;
    srcd_host #(.POLL_MAX(4)) DUT (.*, .flash_dq_i(dq_bus));
    srcd_flash_model u_flash (
        .addr_i(flash_addr_o), .dq_i(dq_bus), .dq_o(mdl_dq), .ce_n_i(flash_ce_n_o),
        .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .reset_n_i(flash_reset_n_o),
        .busy_rd_i(busy_rd), .region_o(region), .bad_o(bad)
    );
    ////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    // watchdog
    initial begin
        #800000;
        miscompares++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // settled point just after an edge
    task automatic wait_clk(inout int n);
        @(posedge mclk_i);
        #1;
        n++;
    endtask
    // one command, held until taken
    task automatic run_cmd(input srcd_op_t op, input logic [22:0] a, input logic [15:0] d);
        int n;
        n = 0;
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_data_i = d;
        cmd_valid_i = 1'b1;
        while (cmd_ready_o !== 1'b1 && n < 100)
            wait_clk(n);
        wait_clk(n);
        cmd_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 3000)
            wait_clk(n);
        wait_clk(n);
        if (n >= 3000)
            miscompares++;
    endtask
    task automatic read_chk(input logic [22:0] a, input logic [15:0] d, input logic inv);
        run_cmd(SRCD_OP_READ, a, 16'h0000);
        if (!inv)
            chk(rdata_o, d);
        chkb(rinv_o, inv);
    endtask
    task automatic do_reset;
        int n;
        n = 0;
        rst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        while (cmd_ready_o !== 1'b1 && n < 100)
            wait_clk(n);
    endtask
    ////////////////////////////////////////////////////////////////
    // entry and region reads
    task automatic t_enter;
        read_chk(23'h000005, 16'h0005 ^ 16'h3c3c, 1'b0);
        run_cmd(SRCD_OP_ENTER, '0, '0);
        chkb(in_region_o, 1'b1);
        chkb(region, 1'b1);
        read_chk(23'h000005, 16'hc005, 1'b0);
        read_chk(23'h00007f, 16'hc07f, 1'b0);
        read_chk(23'h000080, 16'h0000, 1'b1);
        read_chk(23'h010005, 16'h0005 ^ 16'h3c3c, 1'b0);
    endtask
    // program and read back
    task automatic t_prog(input logic [22:0] a, input logic [15:0] d, input logic [7:0] b);
        busy_rd = b;
        run_cmd(SRCD_OP_PROG, a, d);
        chkb(err_o, 1'b0);
        read_chk(a, d, 1'b0);
    endtask
    // exit restores the array
    task automatic t_exit;
        run_cmd(SRCD_OP_EXIT, 23'h4321ab, '0);
        chkb(in_region_o, 1'b0);
        chkb(region, 1'b0);
        read_chk(23'h000005, 16'h0005 ^ 16'h3c3c, 1'b0);
    endtask
    // stuck program, then reset
    task automatic t_stuck_reset;
        run_cmd(SRCD_OP_ENTER, '0, '0);
        busy_rd = 8'd40;
        run_cmd(SRCD_OP_PROG, 23'h000009, 16'h0f0f);
        chkb(err_o, 1'b1);
        do_reset();
        chkb(in_region_o, 1'b0);
        chkb(region, 1'b0);
        busy_rd = 8'd0;
        read_chk(23'h000005, 16'h0005 ^ 16'h3c3c, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        miscompares = 0;
        cmp_count = 0;
        cmd_valid_i = 1'b0;
        cmd_op_i = SRCD_OP_READ;
        cmd_addr_i = '0;
        cmd_data_i = '0;
        busy_rd = 8'd0;
        rst_i = 1'b1;
        do_reset();
        t_enter();
        t_prog(23'h000003, 16'h1234, 8'd0);
        t_prog(23'h00007f, 16'ha5a5, 8'd1);
        t_exit();
        t_stuck_reset();
        chkb(bad, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
